//--- fr_array_model.sv
// File register array answering reads in the same cycle
module file_reg_model
  import incskip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic [4:0] i_addr,
  input incskip_pkg::reg_write_t i_write,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [32];
  // Combinational read of the addressed register
  assign o_data = mem[i_addr];
  // Write lands at the edge that sees the pulse
  always @(posedge i_sys_clk) begin
    if (i_write.en) begin
      mem[i_write.addr] <= i_write.data;
    end
  end
endmodule

//--- incskip_decode.sv
// Opcode decoder for the four-instruction executor
module incskip_decode (
  input wire logic [11:0] i_instr,
  output incskip_pkg::decoded_t o_dec
);
  import incskip_pkg::*;

  // Pattern match against a mask
  function automatic logic op_match(input logic [11:0] op,
                                    input logic [11:0] mask,
                                    input logic [11:0] value);
    op_match = ((op & mask) == value);
  endfunction

  // Instruction class and operand address
  always_comb begin
    o_dec.inc_skip = op_match(i_instr, OP_MASK_REG, OP_INC_SKIP);
    o_dec.nop = op_match(i_instr, OP_MASK_ALL, OP_NOP);
    o_dec.complement = op_match(i_instr, OP_MASK_REG, OP_NOT);
    o_dec.or_into_reg = op_match(i_instr, OP_MASK_REG, OP_OR_REG);
    o_dec.addr = i_instr[4:0];
  end
endmodule

//--- incskip_exec.sv
// Executor for increment-skip, no-op, complement and OR-into-register
module incskip_exec (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_instr_valid,
  input wire logic [11:0] i_instr,
  input wire logic [7:0] i_file_register_operand,
  output logic [4:0] o_reg_addr,
  output incskip_pkg::reg_write_t o_reg_write,
  output logic [7:0] o_w,
  output logic o_zero_flag,
  output logic o_skip_active,
  output logic o_retire
);
  import incskip_pkg::*;

  decoded_t dec;
  exec_state_t state_reg;
  logic take;
  logic discard;
  logic [7:0] inc_sum;
  logic [7:0] not_val;
  logic [7:0] or_val;
  reg_write_t wr_next;

  incskip_decode u_decode (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  // Accept or discard presented words
  // no-op only retires
  assign take = i_instr_valid && (state_reg == ST_EXEC);
  assign discard = i_instr_valid && (state_reg == ST_SKIP);
  assign o_reg_addr = dec.addr;
  assign o_skip_active = (state_reg == ST_SKIP);

  // Operation results
  assign inc_sum = i_file_register_operand + ONE_BYTE;
  assign not_val = i_file_register_operand ^ ALL_ONES;
  assign or_val = i_file_register_operand | o_w;

  // Write-back selection
  always_comb begin
    wr_next.en = 1'b0;
    wr_next.addr = dec.addr;
    wr_next.data = ZERO_BYTE;
    if (take && dec.complement) begin
      wr_next.en = 1'b1;
      wr_next.data = not_val;
    end else if (take && dec.or_into_reg) begin
      wr_next.en = 1'b1;
      wr_next.data = or_val;
    end
  end

  // File register write port
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_reg_write <= '0;
    end else begin
      o_reg_write <= wr_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_w <= W_RESET;
    end else if (take && dec.inc_skip) begin
      o_w <= inc_sum;
    end
  end

  // zero flag from complement or OR
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_zero_flag <= ZERO_RESET;
    end else if (take && dec.complement) begin
      o_zero_flag <= (not_val == ZERO_BYTE);
    end else if (take && dec.or_into_reg) begin
      o_zero_flag <= (or_val == ZERO_BYTE);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_reg <= ST_EXEC;
    end else begin
      case (state_reg)
        ST_EXEC: begin
          if (take && dec.inc_skip && (inc_sum == ZERO_BYTE)) begin
            state_reg <= ST_SKIP;
          end
        end
        ST_SKIP: begin
          if (discard) begin
            state_reg <= ST_EXEC;
          end
        end
        default: begin
          state_reg <= ST_EXEC;
        end
      endcase
    end
  end

  // completion pulse, one cycle after the word, or one cycle after the discarded word on a skip
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_retire <= 1'b0;
    end else begin
      o_retire <= discard ||
                  (take && !(dec.inc_skip && (inc_sum == ZERO_BYTE)));
    end
  end

  // Checks
  a_inc_loads_w: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.inc_skip |=> o_w == $past(inc_sum) && !o_reg_write.en
      && $stable(o_zero_flag))
    else $error("increment did not load W cleanly");

  a_skip_on_zero: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.inc_skip && inc_sum == ZERO_BYTE |=> o_skip_active)
    else $error("zero sum did not start skip");

  a_no_skip_nonzero: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.inc_skip && inc_sum != ZERO_BYTE |=> !o_skip_active
      && o_retire)
    else $error("nonzero sum skipped");

  a_skip_two_cycle: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    o_skip_active && i_instr_valid |=> o_retire && !o_skip_active
      && $stable(o_w) && !o_reg_write.en)
    else $error("skipped word not discarded in one cycle");

  a_nop_quiet: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.nop |=> o_retire && !o_reg_write.en && $stable(o_w)
      && $stable(o_zero_flag) && !o_skip_active)
    else $error("no-op changed state");

  a_not_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.complement |=> o_reg_write.en
      && o_reg_write.data == ~$past(i_file_register_operand)
      && o_reg_write.addr == $past(i_instr[4:0]) && o_retire)
    else $error("complement write wrong");

  a_zero_flag: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && (dec.complement || dec.or_into_reg) |=>
      o_zero_flag == (o_reg_write.data == ZERO_BYTE))
    else $error("zero flag mismatch");

  a_or_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.or_into_reg |=> o_reg_write.en && $stable(o_w)
      && o_reg_write.data == ($past(i_file_register_operand) | o_w))
    else $error("OR write wrong");

  a_addr_follows: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && (dec.complement || dec.or_into_reg) |=>
      o_reg_write.addr == $past(i_instr[4:0]))
    else $error("write address not taken from opcode");

  a_rmw_one_cycle: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && (dec.complement || dec.or_into_reg) |=>
      o_retire && !o_skip_active)
    else $error("read-modify-write not done in one cycle");

  a_skip_waits: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    o_skip_active && !i_instr_valid |=>
      o_skip_active && !o_retire)
    else $error("skip ended without a presented word");

  a_skip_w_zero: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    o_skip_active |->
      o_w == ZERO_BYTE)
    else $error("skip active with nonzero W");

  a_skip_no_retire: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.inc_skip && inc_sum == ZERO_BYTE |=>
      !o_retire)
    else $error("skipping increment retired after one cycle");

  a_idle_quiet: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    !i_instr_valid |=>
      !o_retire && !o_reg_write.en && $stable(o_w))
    else $error("idle cycle changed state");

  a_not_keeps_w: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.complement |=>
      $stable(o_w) && !o_skip_active)
    else $error("complement touched W");

  a_not_zero_set: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && dec.complement && i_file_register_operand == ALL_ONES |=>
      o_zero_flag)
    else $error("complement to zero left flag clear");

  a_unknown_quiet: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    take && !(dec.inc_skip || dec.nop || dec.complement || dec.or_into_reg)
      |=> o_retire && !o_reg_write.en && $stable(o_w) && $stable(o_zero_flag))
    else $error("unknown opcode changed state");
endmodule

//--- incskip_nop_not_or_exec_test.sv
// Self-checking bench for the four-instruction executor
module incskip_nop_not_or_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  import incskip_pkg::*;
  logic i_sys_clk = 0;
  logic i_resetn = 0;
  logic i_instr_valid = 0;
  logic [11:0] i_instr = 12'h000;
  logic [7:0] rd_data, w_out, w_exp = 8'h00;
  logic [4:0] rd_addr;
  logic z_exp = 0;
  logic zero_out, skip_out, retire_out;
  reg_write_t wr_port;
  logic [11:0] ops [4] = '{OP_NOP, OP_INC_SKIP, OP_NOT, OP_OR_REG};
  int err_count = 0, checks = 0, cyc = 0, k;
  incskip_exec dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_file_register_operand(rd_data), .o_reg_addr(rd_addr),
    .o_reg_write(wr_port), .o_w(w_out), .o_zero_flag(zero_out),
    .o_skip_active(skip_out), .o_retire(retire_out));
  file_reg_model m (.i_sys_clk(i_sys_clk), .i_addr(rd_addr),
    .i_write(wr_port), .o_data(rd_data));
  always #10 i_sys_clk = ~i_sys_clk;
  task automatic conclude();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Result of an operation on register value f
  function automatic logic [7:0] calc(logic [11:0] op, logic [7:0] f);
    if ((op & OP_MASK_REG) == OP_INC_SKIP) return f + 8'h01;
    if ((op & OP_MASK_REG) == OP_NOT) return ~f;
    return f | w_exp;
  endfunction
  // One instruction, the skipped word if any, then an idle cycle
  task automatic run(input logic [11:0] op);
    logic [7:0] r;
    logic inc, rmw, skip;
    @(posedge i_sys_clk) #1;
    i_instr_valid = 1;
    i_instr = op;
    r = calc(op, m.mem[op[4:0]]);
    inc = (op & OP_MASK_REG) == OP_INC_SKIP;
    rmw = !inc && op != OP_NOP;
    skip = inc && r == 8'h00;
    if (inc) w_exp = r;
    if (rmw) z_exp = (r == 8'h00);
    @(posedge i_sys_clk) #1;
    i_instr_valid = skip;
    i_instr = OP_NOT | 12'(op[4:0]);
    chk({!skip, skip_out, zero_out, w_out}, {retire_out, skip, z_exp, w_exp});
    chk(rmw ? wr_port : 14'(wr_port.en),
        rmw ? {1'b1, op[4:0], r} : 14'h0);
    if (skip) begin
      @(posedge i_sys_clk) #1;
      i_instr_valid = 0;
      chk({retire_out, skip_out, wr_port.en}, 3'b100);
    end
  endtask
  // Cycle ceiling cuts a hung run short
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h29a3));
    for (int i = 0; i < 32; i++) m.mem[i] = 8'($urandom);
    repeat (6) @(posedge i_sys_clk);
    #1 i_resetn = 1;
    chk({w_out, zero_out, skip_out, retire_out}, 11'h0);
    m.mem[3] = 8'hff;
    m.mem[4] = 8'h00;
    // Corner cases: zero sum skip, zero results, one no-op
    run(OP_INC_SKIP | 12'h003);
    run(OP_OR_REG | 12'h004);
    run(OP_NOT | 12'h003);
    run(OP_INC_SKIP | 12'h01f);
    run(OP_NOP);
    run(OP_OR_REG | 12'h01f);
    repeat (300) begin
      k = $urandom_range(3);
      run(ops[k] | (k != 0 ? 12'($urandom_range(31)) : 12'h000));
    end
    conclude();
  end
endmodule

//--- incskip_pkg.sv
// Constants, types and operation list for the four-instruction executor
package incskip_pkg;
  localparam int unsigned INSTR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;

  // Opcode match values and masks
  localparam logic [11:0] OP_MASK_REG = 12'hfe0;
  localparam logic [11:0] OP_MASK_ALL = 12'hfff;
  localparam logic [11:0] OP_INC_SKIP = 12'h3c0;
  localparam logic [11:0] OP_NOP = 12'h000;
  localparam logic [11:0] OP_NOT = 12'h260;
  localparam logic [11:0] OP_OR_REG = 12'h120;

  // Reset values and byte constants
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  // Decoded instruction
  typedef struct packed {
    logic inc_skip;
    logic nop;
    logic complement;
    logic or_into_reg;
    logic [4:0] addr;
  } decoded_t;

  // File register write request
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } reg_write_t;

  // Executor states
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_SKIP = 2'b10
  } exec_state_t;
endpackage
